// *** fpd_pkg.sv ***
// Package for the fan PWM period and duty block: offsets, fields, resets, timing
package fpd_pkg;
    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_CONFIG     = 7'h4a;
    localparam logic [6:0] IDX_DUTY       = 7'h4c;
    localparam logic [6:0] IDX_DIVISOR    = 7'h4d;
    localparam logic [6:0] IDX_LUT_FIRST  = 7'h50;
    localparam logic [6:0] IDX_LUT_LAST   = 7'h5f;
    // Configuration fields
    localparam int CFG_DIRECT_BIT   = 5;
    localparam int CFG_POLARITY_BIT = 4;
    localparam int CFG_CLKSEL_BIT   = 3;
    // Field widths
    localparam int DIV_W  = 5;
    localparam int DUTY_W = 6;
    localparam int TEMP_W = 7;
    localparam int LUT_N  = 8;
    // Reset values
    localparam logic [7:0]        CONFIG_RST  = 8'h00;
    localparam logic [DIV_W-1:0]  DIVISOR_RST = 5'h17;
    localparam logic [DUTY_W-1:0] DUTY_RST    = 6'h00;
    localparam logic [TEMP_W-1:0] LUT_T_RST   = 7'h7f;
    localparam logic [DUTY_W-1:0] LUT_D_RST   = 6'h3f;
    // Timing: clock and the two base clock rates in Hz
    localparam int CLK_HZ       = 25000000;
    localparam int BASE_FAST_HZ = 360000;
    localparam int BASE_SLOW_HZ = 1400;
    localparam int FAST_DIV     = CLK_HZ / BASE_FAST_HZ;
    localparam int SLOW_DIV     = CLK_HZ / BASE_SLOW_HZ;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fpd_pkg

// *** fpd_fan_pwm.sv ***
// Fan PWM period and duty control with an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps

// Function
// [RULE_01] Five-bit divisor n, reset 10111, gives PWM frequency base over 2n.
// [RULE_02] Base clock comes from one of two rates, 360 kHz or 1.4 kHz.
// [RULE_03] A divisor of zero behaves as one.
// [RULE_04] Unused upper bits of divisor and duty registers read zero.
// [RULE_05] With direct write clear, duty reads back the lookup-selected value, read-only.
// [RULE_06] With direct write set, software duty writes drive the PWM output.
// [RULE_07] Duty field reads zero while a spin-up cycle runs.
// [RULE_08] Duty field resets to zero.
// [RULE_09] Select bit 0 picks 360 kHz, select bit 1 picks 1.4 kHz.
// [RULE_10] Polarity 0: low is fan off, released is on; polarity 1 reverses.
// [RULE_11] Remote temperature above a table entry selects that entry's paired duty.
// [RULE_12] Output active for duty base cycles of each 2n-cycle period, saturating.
module fpd_fan_pwm #(
    parameter int FAST_DIV = fpd_pkg::FAST_DIV,
    parameter int SLOW_DIV = fpd_pkg::SLOW_DIV
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [6:0]  remote_temp,
    input  wire logic        spinup_active,
    input  wire logic        pwm_in,
    output logic             pwm_out,
    output logic             pwm_oe
);
    localparam int DW = fpd_pkg::DUTY_W;

    logic [7:0]                      cfg;
    logic [fpd_pkg::DIV_W-1:0]       divisor;
    logic [DW-1:0]                   sw_duty;
    logic [fpd_pkg::TEMP_W-1:0]      lut_t [fpd_pkg::LUT_N];
    logic [DW-1:0]                   lut_d [fpd_pkg::LUT_N];
    logic [11:0]                     aw_addr;
    logic [7:0]                      w_byte;
    logic                            w_lane0;
    logic [14:0]                     tick_cnt;
    logic [DW-1:0]                   phase;

    // Address decode, separate for the read and write sides
    wire [6:0]  wr_idx     = aw_addr[8:2];
    wire        wr_hi_zero = (aw_addr[11:9] == 3'h0);
    wire [6:0]  rd_idx     = s_axi_araddr[8:2];
    wire        rd_hi_zero = (s_axi_araddr[11:9] == 3'h0);
    wire        wr_is_lut  = wr_hi_zero && wr_idx >= fpd_pkg::IDX_LUT_FIRST
                             && wr_idx <= fpd_pkg::IDX_LUT_LAST;
    wire        rd_is_lut  = rd_hi_zero && rd_idx >= fpd_pkg::IDX_LUT_FIRST
                             && rd_idx <= fpd_pkg::IDX_LUT_LAST;
    wire [6:0]  wr_off     = wr_idx - fpd_pkg::IDX_LUT_FIRST;
    wire [6:0]  rd_off     = rd_idx - fpd_pkg::IDX_LUT_FIRST;
    wire        wr_map     = wr_is_lut || (wr_hi_zero && (wr_idx == fpd_pkg::IDX_CONFIG
                             || wr_idx == fpd_pkg::IDX_DUTY || wr_idx == fpd_pkg::IDX_DIVISOR));
    wire        rd_map     = rd_is_lut || (rd_hi_zero && (rd_idx == fpd_pkg::IDX_CONFIG
                             || rd_idx == fpd_pkg::IDX_DUTY || rd_idx == fpd_pkg::IDX_DIVISOR));
    wire        direct     = cfg[fpd_pkg::CFG_DIRECT_BIT];
    wire        do_write   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire        wr_ok      = do_write && w_lane0;

    // Lookup: the last entry exceeded wins, entries assumed ascending
    logic [DW-1:0] lut_duty;
    always_comb begin
        lut_duty = '0;
        for (int i = 0; i < fpd_pkg::LUT_N; i++) begin
            if (remote_temp > lut_t[i]) begin
                lut_duty = lut_d[i]; // see [RULE_11]
            end
        end
    end

    // Effective duty and what software sees of it
    wire [DW-1:0] eff_duty  = direct ? sw_duty : lut_duty; // see [RULE_05] see [RULE_06]
    wire [DW-1:0] read_duty = spinup_active ? '0 : eff_duty; // see [RULE_07]

    // Read data mux; bits above each field read zero
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (rd_is_lut) begin
            if (rd_off[0]) begin
                rd_byte = {2'b00, lut_d[rd_off[3:1]]};
            end else begin
                rd_byte = {1'b0, lut_t[rd_off[3:1]]};
            end
        end else if (rd_idx == fpd_pkg::IDX_CONFIG) begin
            rd_byte = {2'b00, cfg[5:3], 3'h0};
        end else if (rd_idx == fpd_pkg::IDX_DUTY) begin
            rd_byte = {2'b00, read_duty}; // see [RULE_04]
        end else if (rd_idx == fpd_pkg::IDX_DIVISOR) begin
            rd_byte = {3'h0, divisor}; // see [RULE_04]
        end
        if (!rd_map) begin
            rd_byte = 8'h00;
        end
    end

    // PWM timing: zero divisor acts as one; period is 2n base ticks
    wire [DW-1:0] n_eff      = (divisor == '0) ? 6'h01 : {1'b0, divisor}; // see [RULE_03]
    wire [DW-1:0] period     = {n_eff[4:0], 1'b0}; // see [RULE_01]
    wire [14:0]   tick_limit = cfg[fpd_pkg::CFG_CLKSEL_BIT] ? 15'(SLOW_DIV - 1)
                                                           : 15'(FAST_DIV - 1); // see [RULE_09]
    wire          base_tick  = (tick_cnt >= tick_limit); // see [RULE_02]
    wire          fan_on     = (phase < eff_duty); // see [RULE_12]

    // AXI write channel; address and data taken in either order
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= fpd_pkg::RESP_OKAY;
            aw_addr       <= 12'h000;
            w_byte        <= 8'h00;
            w_lane0       <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte       <= s_axi_wdata[7:0];
                w_lane0      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? fpd_pkg::RESP_OKAY : fpd_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Register file; duty and table writable only with direct write set
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg     <= fpd_pkg::CONFIG_RST;
            divisor <= fpd_pkg::DIVISOR_RST; // see [RULE_01]
            sw_duty <= fpd_pkg::DUTY_RST; // see [RULE_08]
            for (int i = 0; i < fpd_pkg::LUT_N; i++) begin
                lut_t[i] <= fpd_pkg::LUT_T_RST;
                lut_d[i] <= fpd_pkg::LUT_D_RST;
            end
        end else if (wr_ok && wr_hi_zero) begin
            if (wr_idx == fpd_pkg::IDX_CONFIG) begin
                cfg <= {2'b00, w_byte[5:3], 3'h0};
            end
            if (wr_idx == fpd_pkg::IDX_DIVISOR) begin
                divisor <= w_byte[4:0];
            end
            if (wr_idx == fpd_pkg::IDX_DUTY && direct) begin
                sw_duty <= w_byte[5:0]; // see [RULE_06]
            end
            if (wr_is_lut && direct && !wr_off[0]) begin
                lut_t[wr_off[3:1]] <= w_byte[6:0];
            end
            if (wr_is_lut && direct && wr_off[0]) begin
                lut_d[wr_off[3:1]] <= w_byte[5:0];
            end
        end
    end

    // AXI read channel; one read outstanding, answered the cycle after address
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= fpd_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= rd_map ? fpd_pkg::RESP_OKAY : fpd_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Base tick and period phase; phase wraps at 2n so a shrinking divisor recovers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt <= 15'h0000;
            phase    <= 6'h00;
        end else if (base_tick) begin
            tick_cnt <= 15'h0000;
            phase    <= (phase >= period - 6'h01) ? 6'h00 : phase + 6'h01;
        end else begin
            tick_cnt <= tick_cnt + 15'h0001;
        end
    end

    // Open-drain drive; pin is never driven high
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pwm_out <= 1'b0;
            pwm_oe  <= 1'b1;
        end else begin
            pwm_out <= 1'b0;
            pwm_oe  <= cfg[fpd_pkg::CFG_POLARITY_BIT] ? fan_on : !fan_on; // see [RULE_10]
        end
    end

endmodule : fpd_fan_pwm

// *** fpd_fan_pwm_sva.sv ***
// Checker for the fan PWM register slave and its pin drive
`timescale 1ns/1ps
module fpd_fan_pwm_chk (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        spinup_active,
    input wire logic        pwm_out
);
    // Byte addresses of the two watched registers
    localparam logic [11:0] A_DUTY = {3'h0, fpd_pkg::IDX_DUTY, 2'h0};
    localparam logic [11:0] A_DIV  = {3'h0, fpd_pkg::IDX_DIVISOR, 2'h0};
    // Handshakes, named once to keep the properties short
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Read path: answer one edge after the address, clean upper bits
    a_read_latency: assert property (ar_take |=> s_axi_rvalid)
        else $error("read answer not one edge after address");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_divisor_bits: assert property (ar_take && s_axi_araddr == A_DIV
        |=> s_axi_rdata[7:5] == 3'h0) else $error("divisor unused bits set");
    a_duty_bits: assert property (ar_take && s_axi_araddr == A_DUTY
        |=> s_axi_rdata[7:6] == 2'h0) else $error("duty unused bits set");
    a_spinup_zero: assert property (ar_take && s_axi_araddr == A_DUTY
        && spinup_active |=> s_axi_rdata == 32'h0) else $error("duty not zero in spin-up");
    a_unmapped_err: assert property (ar_take && s_axi_araddr == 12'h000
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    // Write path: fixed answer, held until taken, address channel blocked meanwhile
    a_write_resp: assert property (aw_take && w_take
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_aw_blocked: assert property (aw_take |=> !s_axi_awready)
        else $error("write address taken twice");
    // Open drain: the pin is only ever pulled low
    a_pin_low_only: assert property (pwm_out == 1'b0)
        else $error("pin driven high");
endmodule : fpd_fan_pwm_chk

bind fpd_fan_pwm fpd_fan_pwm_chk chk_i (.ref_clk, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .spinup_active,
    .pwm_out);

// *** fpd_fan_stage.sv ***
// Fan drive stage: open-drain pin with pull-up, counts released cycles and rises
`timescale 1ns/1ps
module fpd_fan_stage (
    input  wire logic ref_clk,
    input  wire logic pwm_oe,
    input  wire logic clear,
    output logic      pin,
    output int        high_cnt,
    output int        rise_cnt
);
    logic prev;
    // Pull-up wins whenever the device lets go of the pin
    assign pin = pwm_oe ? 1'b0 : 1'b1;
    // Counts need whole periods in the window to be exact
    always @(posedge ref_clk) begin
        prev <= pin;
        high_cnt <= clear ? 0 : high_cnt + int'(pin);
        rise_cnt <= clear ? 0 : rise_cnt + int'(pin && !prev);
    end
endmodule : fpd_fan_stage

// *** fpd_fan_pwm_tb.sv ***
// Self-checking bench: registers, lookup, spin-up and pin timing against a model
`timescale 1ns/1ps
module fpd_fan_pwm_tb;
    localparam logic [11:0] A_CFG  = {3'h0, fpd_pkg::IDX_CONFIG, 2'h0};
    localparam logic [11:0] A_DUTY = {3'h0, fpd_pkg::IDX_DUTY, 2'h0};
    localparam logic [11:0] A_DIV  = {3'h0, fpd_pkg::IDX_DIVISOR, 2'h0};
    localparam logic [11:0] A_LUT  = {3'h0, fpd_pkg::IDX_LUT_FIRST, 2'h0};
    logic        ref_clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, spinup_active = 0, clr = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [6:0]  remote_temp = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        pwm_out, pwm_oe, pwm_in;
    int          failures = 0, checks_done = 0, cyc = 0, hi, ri;
    // Short base ticks keep the pin windows small
    fpd_fan_pwm #(.FAST_DIV(2), .SLOW_DIV(4)) dut (.ref_clk, .resetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .remote_temp, .spinup_active,
        .pwm_in, .pwm_out, .pwm_oe);
    fpd_fan_stage fan (.ref_clk, .pwm_oe, .clear(clr), .pin(pwm_in), .high_cnt(hi), .rise_cnt(ri));
    always #20 ref_clk = ~ref_clk;
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Bus tasks start just after a rising edge and wait for the slave's answer
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        // Ready stays high between calls; each write sets it high again and none lowers it
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : wr
    task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : rc
    // Direct duty drive, then count released cycles and rises over 64 clocks
    task automatic pw(input int sel, input int pol, input int n, input int du);
        int tick, nn, per, on;
        tick = sel ? 4 : 2;
        nn = (n == 0) ? 1 : n;
        per = 2 * nn * tick;
        on = (du < 2 * nn ? du : 2 * nn) * tick * (64 / per);
        wr(A_CFG, 8'(32 + 16 * pol + 8 * sel), 2'h0);
        wr(A_DIV, 8'(n), 2'h0);
        wr(A_DUTY, 8'(du), 2'h0);
        repeat (40) @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (64) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("released", pol ? 64 - on : on, hi);
        chk("rises", (du == 0 || du >= 2 * nn) ? 0 : 64 / per, ri);
        @(posedge ref_clk);
        $display("pin test sel %0d pol %0d n %0d duty %0d done", sel, pol, n, du);
    endtask : pw
    task automatic complete_run;
        $display("Counts: %0d comparisons, %0d mismatches", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    initial begin
        void'($urandom(32'hbd705f86));
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rc(A_DIV, 32'h17, 2'h0);
        rc(A_DUTY, 32'h0, 2'h0);
        wr(A_DIV, 8'hff, 2'h0);
        rc(A_DIV, 32'h1f, 2'h0);
        rc(12'h0, 32'h0, 2'h2);
        wr(12'h0, 8'h01, 2'h2);
        wr(A_CFG, 8'h20, 2'h0);
        wr(A_DUTY, 8'hff, 2'h0);
        rc(A_DUTY, 32'h3f, 2'h0);
        wr(A_LUT, 8'h10, 2'h0);
        wr(A_LUT + 12'h4, 8'h2a, 2'h0);
        $display("register test done");
        pw(1, 0, 2, 1);
        pw(0, 0, 2, 1);
        pw(0, 1, 2, 3);
        pw(0, 0, 0, 1);
        pw(0, 0, 2, 63);
        wr(A_CFG, 8'h00, 2'h0);
        wr(A_DUTY, 8'h05, 2'h0);
        // Random temperatures, spin-up on every other read
        for (int i = 0; i < 8; i++) begin
            remote_temp <= (i == 2) ? 7'h05 : 7'($urandom);
            spinup_active <= i[0];
            @(posedge ref_clk);
            rc(A_DUTY, (spinup_active || remote_temp <= 7'h10) ? 32'h0 : 32'h2a,
               2'h0);
        end
        $display("lookup test done");
        complete_run;
    end
endmodule : fpd_fan_pwm_tb
